// ---- hdl/hiop_defs.svh ----
// Port, index, field and reset constants for the host I/O port decoder
`ifndef HIOP_DEFS_SVH
`define HIOP_DEFS_SVH

// ------------------------------------------------------------
// Host I/O ports
// ------------------------------------------------------------
`define HIOP_PORT_SSE_LO   16'h03c3
`define HIOP_PORT_SSE_HI   16'h46e8
`define HIOP_PORT_MISC_WR  16'h03c2
`define HIOP_PORT_MISC_RD  16'h03cc
`define HIOP_PORT_COMPAT   16'h03bf
`define HIOP_PORT_MODE_M   16'h03b8
`define HIOP_PORT_MODE_C   16'h03d8
`define HIOP_PORT_IDX_M    16'h03b4
`define HIOP_PORT_IDX_C    16'h03d4
`define HIOP_PORT_DAT_M    16'h03b5
`define HIOP_PORT_DAT_C    16'h03d5

// ------------------------------------------------------------
// Indexed timing register numbers
// ------------------------------------------------------------
`define HIOP_IX_HT        6'h00
`define HIOP_IX_HBS       6'h02
`define HIOP_IX_HBE       6'h03
`define HIOP_IX_HSS       6'h04
`define HIOP_IX_HSE       6'h05
`define HIOP_IX_VT        6'h06
`define HIOP_IX_OVL       6'h07
`define HIOP_IX_MRA       6'h09
`define HIOP_IX_VSS       6'h10
`define HIOP_IX_VSE       6'h11
`define HIOP_IX_VDE       6'h12
`define HIOP_IX_VBS       6'h15
`define HIOP_IX_VBE       6'h16
`define HIOP_IX_LAST_STD  6'h18
`define HIOP_IX_EXT_LO    6'h30
`define HIOP_IX_EXT_HI    6'h37
`define HIOP_IX_KEYFREE   6'h33
`define HIOP_IX_SSEL      6'h34
`define HIOP_IX_OVH       6'h35
`define HIOP_IX_HOV       6'h3f

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define HIOP_SSE_EN_LO    0
`define HIOP_SSE_EN_HI    3
`define HIOP_MISC_COLOR   0
`define HIOP_MODE_KEY_A   7
`define HIOP_MODE_PAGE    6
`define HIOP_MODE_KEY_B   5
`define HIOP_COMPAT_PAGE  1
`define HIOP_SSEL_RELOC   3
`define HIOP_VSE_PROT     7
`define HIOP_OVL_VT8      0
`define HIOP_OVL_VDE8     1
`define HIOP_OVL_VSS8     2
`define HIOP_OVL_VBS8     3
`define HIOP_OVL_VT9      5
`define HIOP_OVL_VDE9     6
`define HIOP_OVL_VSS9     7
`define HIOP_MRA_VBS9     5
`define HIOP_OVH_VBS10    0
`define HIOP_OVH_VT10     1
`define HIOP_OVH_VDE10    2
`define HIOP_OVH_VSS10    3
`define HIOP_HOV_HT8      0
`define HIOP_HOV_HBS8     2
`define HIOP_HOV_HSS8     4
`define HIOP_HSE_HBE5     7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define HIOP_RST_BYTE     8'h00
`define HIOP_RST_IDX      6'h00
`define HIOP_RST_HDE      3'h0

`endif

// ---- hdl/hiop_pkg.sv ----
// Types shared by the host I/O port decoder
package hiop_pkg;
    typedef logic [7:0]  hiop_byte_t;
    typedef logic [5:0]  hiop_idx_t;
    typedef logic [15:0] hiop_port_t;
    typedef logic [8:0]  hiop_hpos_t;
    typedef logic [10:0] hiop_vpos_t;
endpackage

// ---- hdl/hiop_top.sv ----
// Host I/O port decode, extension key and indexed timing registers
`timescale 1ns/100ps
`include "hiop_defs.svh"

// What this block does
// - Enable register at 3C3 or 46E8
// - Enable register starts at 3C3
// - Disabled subsystem ignores all other accesses
// - At 3C3 bit 0 enables; 7:4 zero
// - At 46E8 bit 3 enables
// - Mode control at 3B8/3D8, bit 6 mirrors page
// - Compat port 3BF bit 1 second page
// - Key sets only while page bit set
// - Key bits 1,1 set; otherwise clear
// - Misc bit 0 picks 3DX or 3BX
// - Index port at 3B4 or 3D4
// - Data port reaches indexed register
// - Indices above 18 need key, except 33/35
// - Index 35 guarded by index 11 bit 7
// - Implemented indices listed, all read/write
// - Vertical sync start 11 bits assembled
// - Horizontal total/blank/sync start 9 bits
// - Horizontal blank end and sync end assembled
// - Skew delays horizontal display enable
// - Vertical blank start and end assembled
// - Vertical total assembled
// - Vertical display end assembled
// - Vertical sync end four bits
module hiop_top
    import hiop_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire hiop_port_t io_addr_in,
    input  wire logic       io_wr_in,
    input  wire logic       io_rd_in,
    input  wire hiop_byte_t io_wdata_in,
    input  wire logic       hde_in,
    output hiop_byte_t      io_rdata_out,
    output logic            io_rvalid_out,
    output logic            video_en_out,
    output logic            color_mode_out,
    output logic            key_out,
    output logic            second_page_out,
    output hiop_hpos_t      horiz_total_out,
    output hiop_hpos_t      horiz_blank_start_out,
    output hiop_hpos_t      horiz_sync_start_out,
    output logic [5:0]      horiz_blank_end_value_out,
    output logic [4:0]      horiz_sync_end_out,
    output hiop_vpos_t      vert_total_value_out,
    output hiop_vpos_t      vert_display_end_value_out,
    output hiop_vpos_t      vert_blank_start_value_out,
    output hiop_byte_t      vert_blank_end_out,
    output hiop_vpos_t      vert_sync_start_out,
    output logic [3:0]      vert_sync_end_out,
    output logic            hde_skewed_out
);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic hiop_impl(input hiop_idx_t i);
        hiop_impl = (i <= `HIOP_IX_LAST_STD) || (i == `HIOP_IX_HOV) ||
                    (i >= `HIOP_IX_EXT_LO && i <= `HIOP_IX_EXT_HI);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    hiop_byte_t sse_q;
    hiop_byte_t misc_q;
    logic       key_a_q;
    logic       key_b_q;
    logic       page_q;
    logic       key_q;
    hiop_idx_t  idx_q;
    hiop_byte_t crtc_q [64];
    logic [2:0] hde_sh_q;

    // ------------------------------------------------------------
    // Port decode
    // ------------------------------------------------------------
    wire        reloc_w  = crtc_q[`HIOP_IX_SSEL][`HIOP_SSEL_RELOC];
    wire        color_w  = misc_q[`HIOP_MISC_COLOR];
    wire        hit_sse  = io_addr_in == (reloc_w ? `HIOP_PORT_SSE_HI
                                                  : `HIOP_PORT_SSE_LO);
    // Enable bit position follows the active location
    wire        enabled  = reloc_w ? sse_q[`HIOP_SSE_EN_HI]
                                   : sse_q[`HIOP_SSE_EN_LO];
    // Everything but the enable register goes dark while disabled
    wire        hit_misw = enabled && io_addr_in == `HIOP_PORT_MISC_WR;
    wire        hit_misr = enabled && io_addr_in == `HIOP_PORT_MISC_RD;
    wire        hit_comp = enabled && io_addr_in == `HIOP_PORT_COMPAT;
    wire        hit_mode = enabled && io_addr_in ==
                           (color_w ? `HIOP_PORT_MODE_C : `HIOP_PORT_MODE_M);
    wire        hit_idx  = enabled && io_addr_in ==
                           (color_w ? `HIOP_PORT_IDX_C : `HIOP_PORT_IDX_M);
    wire        hit_dat  = enabled && io_addr_in ==
                           (color_w ? `HIOP_PORT_DAT_C : `HIOP_PORT_DAT_M);

    // ------------------------------------------------------------
    // Write gating of indexed registers
    // ------------------------------------------------------------
    wire        vse_prot = crtc_q[`HIOP_IX_VSE][`HIOP_VSE_PROT];
    wire        key_ok   = (idx_q <= `HIOP_IX_LAST_STD) || (idx_q == `HIOP_IX_KEYFREE) ||
                           key_q;
    wire        gate_ok  = (idx_q == `HIOP_IX_OVH) ? !vse_prot : key_ok;
    wire        dat_wr   = io_wr_in && hit_dat;
    wire        wr_ok    = dat_wr && gate_ok && hiop_impl(idx_q);
    wire        key_pair = io_wdata_in[`HIOP_MODE_KEY_A] && io_wdata_in[`HIOP_MODE_KEY_B];
    wire        mode_wr  = io_wr_in && hit_mode;
    hiop_byte_t cur_val;
    assign cur_val = crtc_q[idx_q];

    // ------------------------------------------------------------
    // Indexed register storage
    // ------------------------------------------------------------
    for (genvar gi = 0; gi < 64; gi++) begin : g_crtc
        if (hiop_impl(6'(gi))) begin : g_impl
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    crtc_q[gi] <= `HIOP_RST_BYTE;
                end else if (wr_ok && idx_q == 6'(gi)) begin
                    crtc_q[gi] <= io_wdata_in;
                end
            end
        end else begin : g_none
            // Holes read as zero and swallow writes
            assign crtc_q[gi] = `HIOP_RST_BYTE;
        end
    end

    // ------------------------------------------------------------
    // Directly addressed registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sse_q   <= `HIOP_RST_BYTE;
            misc_q  <= `HIOP_RST_BYTE;
            idx_q   <= `HIOP_RST_IDX;
            page_q  <= 1'b0;
            key_a_q <= 1'b0;
            key_b_q <= 1'b0;
            key_q   <= 1'b0;
        end else begin
            if (io_wr_in && hit_sse) begin
                sse_q <= {4'h0, io_wdata_in[`HIOP_SSE_EN_HI], 2'b00,
                          io_wdata_in[`HIOP_SSE_EN_LO]};
            end
            if (io_wr_in && hit_misw) begin
                misc_q <= io_wdata_in;
            end
            if (io_wr_in && hit_idx) begin
                idx_q <= io_wdata_in[5:0];
            end
            if (io_wr_in && hit_comp) begin
                page_q <= io_wdata_in[`HIOP_COMPAT_PAGE];
            end
            if (mode_wr) begin
                key_a_q <= io_wdata_in[`HIOP_MODE_KEY_A];
                key_b_q <= io_wdata_in[`HIOP_MODE_KEY_B];
                key_q   <= key_pair && page_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire        rd_hit  = io_rd_in && (hit_sse || hit_misr || hit_mode ||
                                       hit_idx || hit_dat);
    wire hiop_byte_t mode_rd = {key_a_q, page_q, key_b_q, 5'h00};
    wire hiop_byte_t rd_mux  = hit_sse  ? sse_q :
                               hit_misr ? misc_q :
                               hit_mode ? mode_rd :
                               hit_idx  ? {2'b00, idx_q} :
                               cur_val;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            io_rdata_out  <= `HIOP_RST_BYTE;
            io_rvalid_out <= 1'b0;
        end else begin
            io_rdata_out  <= rd_hit ? rd_mux : `HIOP_RST_BYTE;
            io_rvalid_out <= rd_hit;
        end
    end

    // ------------------------------------------------------------
    // Timing value assembly
    // ------------------------------------------------------------
    wire hiop_byte_t ovl = crtc_q[`HIOP_IX_OVL];
    wire hiop_byte_t ovh = crtc_q[`HIOP_IX_OVH];
    wire hiop_byte_t hov = crtc_q[`HIOP_IX_HOV];
    wire hiop_byte_t horiz_blank_end_value = crtc_q[`HIOP_IX_HBE];
    wire hiop_byte_t hse = crtc_q[`HIOP_IX_HSE];
    wire hiop_hpos_t ht_w  = {hov[`HIOP_HOV_HT8],  crtc_q[`HIOP_IX_HT]};
    wire hiop_hpos_t hbs_w = {hov[`HIOP_HOV_HBS8], crtc_q[`HIOP_IX_HBS]};
    wire hiop_hpos_t hss_w = {hov[`HIOP_HOV_HSS8], crtc_q[`HIOP_IX_HSS]};
    wire [5:0]       hbe_w = {hse[`HIOP_HSE_HBE5], horiz_blank_end_value[4:0]};
    wire hiop_vpos_t vt_w  = {ovh[`HIOP_OVH_VT10], ovl[`HIOP_OVL_VT9],
                              ovl[`HIOP_OVL_VT8], crtc_q[`HIOP_IX_VT]};
    wire hiop_vpos_t vde_w = {ovh[`HIOP_OVH_VDE10], ovl[`HIOP_OVL_VDE9],
                              ovl[`HIOP_OVL_VDE8], crtc_q[`HIOP_IX_VDE]};
    wire hiop_vpos_t vbs_w = {ovh[`HIOP_OVH_VBS10],
                              crtc_q[`HIOP_IX_MRA][`HIOP_MRA_VBS9],
                              ovl[`HIOP_OVL_VBS8], crtc_q[`HIOP_IX_VBS]};
    wire hiop_vpos_t vss_w = {ovh[`HIOP_OVH_VSS10], ovl[`HIOP_OVL_VSS9],
                              ovl[`HIOP_OVL_VSS8], crtc_q[`HIOP_IX_VSS]};
    // Skew counted in clocks: one character per clock assumed here
    wire [3:0]       hde_taps = {hde_sh_q, hde_in};
    wire             hde_sel  = hde_taps[horiz_blank_end_value[6:5]];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            horiz_total_out            <= '0;
            horiz_blank_start_out      <= '0;
            horiz_sync_start_out       <= '0;
            horiz_blank_end_value_out  <= '0;
            horiz_sync_end_out         <= '0;
            vert_total_value_out       <= '0;
            vert_display_end_value_out <= '0;
            vert_blank_start_value_out <= '0;
            vert_blank_end_out         <= '0;
            vert_sync_start_out        <= '0;
            vert_sync_end_out          <= '0;
            hde_sh_q                   <= `HIOP_RST_HDE;
            hde_skewed_out             <= 1'b0;
            video_en_out               <= 1'b0;
            color_mode_out             <= 1'b0;
            key_out                    <= 1'b0;
            second_page_out            <= 1'b0;
        end else begin
            horiz_total_out            <= ht_w;
            horiz_blank_start_out      <= hbs_w;
            horiz_sync_start_out       <= hss_w;
            horiz_blank_end_value_out  <= hbe_w;
            horiz_sync_end_out         <= hse[4:0];
            vert_total_value_out       <= vt_w;
            vert_display_end_value_out <= vde_w;
            vert_blank_start_value_out <= vbs_w;
            vert_blank_end_out         <= crtc_q[`HIOP_IX_VBE];
            vert_sync_start_out        <= vss_w;
            vert_sync_end_out          <= crtc_q[`HIOP_IX_VSE][3:0];
            hde_sh_q                   <= hde_taps[2:0];
            hde_skewed_out             <= hde_sel;
            video_en_out               <= enabled;
            color_mode_out             <= color_w;
            key_out                    <= key_q;
            second_page_out            <= page_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_sse_default_port: assert property (
        $past(rst_in) |-> !reloc_w && !video_en_out)
        else $error("enable register not at default port after reset");

    chk_disabled_ignore: assert property (
        io_rd_in && !enabled && !hit_sse |=> !io_rvalid_out)
        else $error("read answered while subsystem disabled");

    chk_enable_bit_sel: assert property (
        io_wr_in && hit_sse && !reloc_w && io_wdata_in[`HIOP_SSE_EN_LO]
        |=> enabled ##1 video_en_out)
        else $error("low enable bit did not enable subsystem");

    chk_mode_page_read: assert property (
        io_rd_in && hit_mode |=> io_rvalid_out &&
        io_rdata_out[`HIOP_MODE_PAGE] == $past(page_q) && io_rdata_out[4:0] == 5'h00)
        else $error("mode control readback wrong");

    chk_key_needs_page: assert property (
        $rose(key_q) |-> $past(page_q) && $past(mode_wr))
        else $error("key set without second page bit");

    chk_key_clear: assert property (
        mode_wr && !key_pair |=> !key_q ##1 !key_out)
        else $error("key not cleared by other bit pair");

    chk_data_write: assert property (
        wr_ok |=> cur_val == $past(io_wdata_in))
        else $error("permitted data write not stored");

    chk_ext_block: assert property (
        dat_wr && !key_q && idx_q > `HIOP_IX_LAST_STD && idx_q != `HIOP_IX_KEYFREE &&
        idx_q != `HIOP_IX_OVH |=> $stable(cur_val))
        else $error("extended index written without key");

    chk_ovh_protect: assert property (
        dat_wr && idx_q == `HIOP_IX_OVH && vse_prot |=> $stable(cur_val))
        else $error("protected index 35 was written");

    chk_vss_assembly: assert property (
        ##1 vert_sync_start_out == $past(vss_w) &&
        vert_sync_start_out[10] == $past(ovh[`HIOP_OVH_VSS10]))
        else $error("vertical sync start assembled wrong");

    chk_hole_reads_zero: assert property (
        io_rd_in && hit_dat && !hiop_impl(idx_q) |=> io_rvalid_out && io_rdata_out == 8'h00)
        else $error("unimplemented index read nonzero");

    chk_sse_reserved: assert property (
        io_rd_in && hit_sse |=> io_rdata_out[7:4] == 4'h0)
        else $error("enable register reserved bits not zero");

    chk_reloc_enable: assert property (
        io_wr_in && hit_sse && reloc_w && io_wdata_in[`HIOP_SSE_EN_HI]
        |=> enabled)
        else $error("high enable bit did not enable relocated subsystem");

    chk_port_group: assert property (
        io_rd_in && io_addr_in == (color_w ? `HIOP_PORT_IDX_M : `HIOP_PORT_DAT_C)
        |=> !io_rvalid_out)
        else $error("port of the other emulation group answered");

    chk_ovh_keyfree: assert property (
        dat_wr && idx_q == `HIOP_IX_OVH && !vse_prot
        |=> cur_val == $past(io_wdata_in))
        else $error("unprotected index 35 write lost");

    chk_page_copy: assert property (
        io_wr_in && hit_comp
        |-> ##2 second_page_out == $past(io_wdata_in[`HIOP_COMPAT_PAGE], 2))
        else $error("second page bit not taken");

    chk_skew_zero: assert property (
        !$past(rst_in) && $past(horiz_blank_end_value[6:5]) == 2'b00
        |-> hde_skewed_out == $past(hde_in))
        else $error("display enable skew of zero not one clock");

    cov_key_set: cover property (mode_wr && key_pair && page_q ##1 key_q);
    cov_ovh_protect: cover property (dat_wr && idx_q == `HIOP_IX_OVH && vse_prot);
    cov_relocate: cover property ($rose(reloc_w));
    cov_ext_write: cover property (wr_ok && idx_q > `HIOP_IX_LAST_STD);
    cov_disabled_rd: cover property (io_rd_in && !enabled && hit_sse);

endmodule // hiop_top

// ---- tb/hiop_host.sv ----
// Host processor model issuing I/O port reads and writes
`timescale 1ns/100ps
module hiop_host
    import hiop_pkg::*;
(
    input  wire logic       clk_in,
    input  wire hiop_byte_t rdata_in,
    input  wire logic       rvalid_in,
    output hiop_port_t      addr_out,
    output logic            wr_out,
    output logic            rd_out,
    output hiop_byte_t      wdata_out
);
    initial begin
        addr_out  = 16'h0000;
        wr_out    = 1'h0;
        rd_out    = 1'h0;
        wdata_out = 8'h00;
    end

    // One-cycle write strobe; data driven inverted once released
    task automatic io_write(input hiop_port_t a, input hiop_byte_t d);
        @(posedge clk_in);
        addr_out  <= a;
        wdata_out <= d;
        wr_out    <= 1'h1;
        @(posedge clk_in);
        wr_out    <= 1'h0;
        wdata_out <= ~d;
    endtask

    // Answer stands for one cycle after the taking edge; caught at the next edge
    task automatic io_read(input hiop_port_t a, output hiop_byte_t d, output logic v);
        @(posedge clk_in);
        addr_out <= a;
        rd_out   <= 1'h1;
        @(posedge clk_in);
        rd_out   <= 1'h0;
        @(posedge clk_in);
        d = rdata_in;
        v = rvalid_in;
    endtask
endmodule // hiop_host

// ---- tb/host_io_port_decode_and_unlock_test.sv ----
// Self-checking bench for the host I/O port decoder
`timescale 1ns/100ps
module host_io_port_decode_and_unlock_test;
    import hiop_pkg::*;
    typedef struct packed {logic w; hiop_port_t a; hiop_byte_t d; logic v;} hiop_row_s;
    logic       clk = 1'h0;
    logic       rst = 1'h1;
    logic       hde = 1'h0;
    hiop_port_t io_addr;
    logic       io_wr, io_rd, io_rvalid, video_en, color_mode, key, page, hde_sk;
    hiop_byte_t io_wdata, io_rdata, vbe, rd_d;
    hiop_hpos_t ht, hbs, hss;
    logic [5:0] horiz_blank_end_value;
    logic [4:0] hse;
    logic [3:0] vse;
    hiop_vpos_t vt, vert_display_end_value, vert_blank_start_value, vss;
    logic       rd_v;
    int         mismatches = 0;
    int         checks = 0;
    // w, port, data or expected read data, expected answer
    hiop_row_s rows [51] = '{
        '{1'h0,16'h03b5,8'h00,1'h0}, '{1'h0,16'h03c3,8'h00,1'h1},
        '{1'h1,16'h46e8,8'h08,1'h0}, '{1'h0,16'h03c3,8'h00,1'h1},
        '{1'h1,16'h03c3,8'hf1,1'h0}, '{1'h0,16'h03c3,8'h01,1'h1},
        '{1'h1,16'h03b4,8'h07,1'h0}, '{1'h0,16'h03b4,8'h07,1'h1},
        '{1'h1,16'h03b5,8'hff,1'h0}, '{1'h0,16'h03b5,8'hff,1'h1},
        '{1'h0,16'h03d5,8'h00,1'h0}, '{1'h1,16'h03b4,8'h30,1'h0},
        '{1'h1,16'h03b5,8'h55,1'h0}, '{1'h0,16'h03b5,8'h00,1'h1},
        '{1'h1,16'h03b4,8'h33,1'h0}, '{1'h1,16'h03b5,8'h5a,1'h0},
        '{1'h0,16'h03b5,8'h5a,1'h1}, '{1'h1,16'h03b4,8'h35,1'h0},
        '{1'h1,16'h03b5,8'h0f,1'h0}, '{1'h0,16'h03b5,8'h0f,1'h1},
        '{1'h1,16'h03b4,8'h11,1'h0}, '{1'h1,16'h03b5,8'h87,1'h0},
        '{1'h1,16'h03b4,8'h35,1'h0}, '{1'h1,16'h03b5,8'h00,1'h0},
        '{1'h0,16'h03b5,8'h0f,1'h1}, '{1'h1,16'h03b4,8'h11,1'h0},
        '{1'h1,16'h03b5,8'h07,1'h0}, '{1'h1,16'h03b4,8'h20,1'h0},
        '{1'h1,16'h03b5,8'h33,1'h0}, '{1'h0,16'h03b5,8'h00,1'h1},
        '{1'h1,16'h03b8,8'ha0,1'h0}, '{1'h0,16'h03b8,8'ha0,1'h1},
        '{1'h1,16'h03b4,8'h30,1'h0}, '{1'h1,16'h03b5,8'h55,1'h0},
        '{1'h0,16'h03b5,8'h00,1'h1}, '{1'h0,16'h03bf,8'h00,1'h0},
        '{1'h1,16'h03bf,8'h03,1'h0}, '{1'h1,16'h03b8,8'ha0,1'h0},
        '{1'h0,16'h03b8,8'he0,1'h1}, '{1'h1,16'h03b5,8'h55,1'h0},
        '{1'h0,16'h03b5,8'h55,1'h1}, '{1'h1,16'h03b8,8'h20,1'h0},
        '{1'h0,16'h03b8,8'h60,1'h1}, '{1'h1,16'h03b5,8'haa,1'h0},
        '{1'h0,16'h03b5,8'h55,1'h1}, '{1'h1,16'h03c2,8'h01,1'h0},
        '{1'h0,16'h03cc,8'h01,1'h1}, '{1'h0,16'h03b4,8'h00,1'h0},
        '{1'h0,16'h03d4,8'h30,1'h1}, '{1'h1,16'h03d8,8'ha0,1'h0},
        '{1'h0,16'h03d8,8'he0,1'h1}};
    // Index in the upper byte, value in the lower
    logic [15:0] tw [15] = '{16'h00a1, 16'h02b2, 16'h04c3, 16'h3f15, 16'h036d,
        16'h059e, 16'h0611, 16'h07ff, 16'h0920, 16'h1044, 16'h1107, 16'h1266,
        16'h1577, 16'h1688, 16'h350f};

    always #25 clk = ~clk;

    hiop_host host (.clk_in(clk), .rdata_in(io_rdata), .rvalid_in(io_rvalid),
        .addr_out(io_addr), .wr_out(io_wr), .rd_out(io_rd), .wdata_out(io_wdata));

    hiop_top DUT (.clk_in(clk), .rst_in(rst), .io_addr_in(io_addr), .io_wr_in(io_wr),
        .io_rd_in(io_rd), .io_wdata_in(io_wdata), .hde_in(hde), .io_rdata_out(io_rdata),
        .io_rvalid_out(io_rvalid), .video_en_out(video_en), .color_mode_out(color_mode),
        .key_out(key), .second_page_out(page), .horiz_total_out(ht),
        .horiz_blank_start_out(hbs), .horiz_sync_start_out(hss),
        .horiz_blank_end_value_out(horiz_blank_end_value), .horiz_sync_end_out(hse),
        .vert_total_value_out(vt), .vert_display_end_value_out(vert_display_end_value),
        .vert_blank_start_value_out(vert_blank_start_value), .vert_blank_end_out(vbe),
        .vert_sync_start_out(vss), .vert_sync_end_out(vse), .hde_skewed_out(hde_sk));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Reset leaves the subsystem off, unlocked state cleared, timing zero
    task automatic check_reset;
        repeat (2) @(posedge clk);
        #1;
        check({15'h0, video_en}, 16'h0000);
        check({key, page, color_mode, io_rvalid}, 16'h0000);
        check({7'h0, ht}, 16'h0000);
        check({5'h0, vt}, 16'h0000);
        host.io_read(16'h03c3, rd_d, rd_v);
        check({7'h0, rd_v, rd_d}, 16'h0100);
        host.io_read(16'h46e8, rd_d, rd_v);
        check({15'h0, rd_v}, 16'h0000);
    endtask

    // Long enough for every test several times over
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        check_reset;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                host.io_write(rows[i].a, rows[i].d);
            end else begin
                host.io_read(rows[i].a, rd_d, rd_v);
                check({7'h0, rd_v, rd_d}, {7'h0, rows[i].v, rows[i].d});
            end
        end
        repeat (2) @(posedge clk);
        #1;
        check({video_en, color_mode, key, page}, 16'h000f);
        foreach (tw[i]) begin
            host.io_write(16'h03d4, tw[i][15:8]);
            host.io_write(16'h03d5, tw[i][7:0]);
        end
        repeat (3) @(posedge clk);
        #1;
        check({7'h0, ht}, 16'h01a1);
        check({7'h0, hbs}, 16'h01b2);
        check({7'h0, hss}, 16'h01c3);
        check({5'h0, horiz_blank_end_value, hse}, 16'h05be);
        check({5'h0, vt}, 16'h0711);
        check({5'h0, vert_display_end_value}, 16'h0766);
        check({5'h0, vert_blank_start_value}, 16'h0777);
        check({4'h0, vse, vbe}, 16'h0788);
        check({5'h0, vss}, 16'h0744);
        // Skew of three: rises on the fourth edge only
        @(posedge clk);
        hde <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        check({15'h0, hde_sk}, 16'h0000);
        @(posedge clk);
        #1;
        check({15'h0, hde_sk}, 16'h0001);
        @(posedge clk);
        hde <= 1'h0;
        // Move the enable register to the alternate port
        host.io_write(16'h03d4, 8'h34);
        host.io_write(16'h03d5, 8'h08);
        host.io_write(16'h46e8, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        check({15'h0, video_en}, 16'h0000);
        host.io_write(16'h46e8, 8'h08);
        repeat (2) @(posedge clk);
        #1;
        check({15'h0, video_en}, 16'h0001);
        host.io_read(16'h03c3, rd_d, rd_v);
        check({7'h0, rd_v, rd_d}, 16'h0000);
        host.io_read(16'h46e8, rd_d, rd_v);
        check({7'h0, rd_v, rd_d}, 16'h0108);
        // Reset in mid-run brings the port back to the power-up place
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        check_reset;
        finish_test;
    end
endmodule // host_io_port_decode_and_unlock_test
